// file: floppy_ctrl_config_and_relseek.sv
/*
  Drive positioning and configuration engine of a floppy controller:
  timer setup, feature configuration, drive status and version query,
  relative seek, recalibrate and a read/write execution phase with
  implied seek, head load/unload timing and DMA or host transfer requests.
  Assumes one drive, inputs synchronous to clk, and an Avalon-MM master.
*/
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module floppy_ctrl_config_and_relseek #(
  parameter int QUARTER_CYC = fd_pkg::QUARTER_MS_NS / fd_pkg::CLK_NS,
  parameter int XFER_BYTES = fd_pkg::XFER_BYTES_DEF,
  parameter logic [7:0] VERSION_CODE = 8'h5A // arbitrary value
)(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm register slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // drive side
  output logic stepPulse,
  output logic stepDirIn,
  output logic headLoad,
  input wire logic trackZeroSense,
  input wire logic writeProtect,
  input wire logic driveReady,
  // transfer signalling
  output logic dmaRequest,
  input wire logic dmaAck,
  output logic hostTransferReady,
  output logic controllerIrq
);

  generate
    if (QUARTER_CYC < fd_pkg::MUL_DEN || QUARTER_CYC > 1000000 || XFER_BYTES < 1
        || XFER_BYTES > 256)
    begin : g_bad
      $error("unsupported parameter values");
    end
  endgenerate

  fd_pkg::eng_state_t state_ff;
  fd_pkg::eng_op_t op_ff;
  logic ack_ff;
  logic [31:0] readdata_ff;
  logic [3:0] unloadCode_ff, stepCode_ff, fifo_threshold_ff;
  logic [6:0] loadCode_ff;
  logic nonDma_ff, impliedSeek_ff, fifoDisable_ff, pollDisable_ff;
  logic [7:0] precomp_ff, remaining_ff, stepsDone_ff, target_ff, pcn_ff, st0_ff;
  logic [2:0] rate_ff;
  logic dirIn_ff, irq_ff, pollDone_ff, headLoaded_ff, stepPulse_ff, reqGap_ff;
  logic [23:0] prescale_ff;
  logic [8:0] timer_ff, unload_ff, bytesLeft_ff;
  logic [7:0] stepWidth_ff;
  logic [4:0] burstLeft_ff;
  logic wrOk, rdOk, tick, stepNow, finishNow, finishFault, loadNow, xferDone;
  logic byteAck, pollFire, needSeek;
  logic [7:0] st3;
  logic [31:0] rdMux;

  // timer lengths in quarter ms, linear in the code; code 0 of unload and load gives 256
  function automatic logic [8:0] unloadQ(input logic [3:0] c);
    return (c == 4'h0) ? fd_pkg::UNLOAD_ZERO_Q : 9'(fd_pkg::UNLOAD_STEP_Q * c);
  endfunction
  function automatic logic [8:0] loadQ(input logic [6:0] c);
    return (c == 7'h00) ? fd_pkg::LOAD_ZERO_Q : 9'(fd_pkg::LOAD_STEP_Q * c);
  endfunction
  function automatic logic [8:0] stepQ(input logic [3:0] c);
    return 9'(fd_pkg::STEP_TOP_Q - {5'h00, c});
  endfunction
  // cycles per quarter-ms tick at the selected rate
  function automatic logic [23:0] rateDiv(input logic [2:0] r);
    unique case (r)
      fd_pkg::RATE_2M: return 24'(QUARTER_CYC * fd_pkg::MUL_2M / fd_pkg::MUL_DEN);
      fd_pkg::RATE_1M: return 24'(QUARTER_CYC * fd_pkg::MUL_1M / fd_pkg::MUL_DEN);
      fd_pkg::RATE_500K: return 24'(QUARTER_CYC * fd_pkg::MUL_500K / fd_pkg::MUL_DEN);
      fd_pkg::RATE_300K: return 24'(QUARTER_CYC * fd_pkg::MUL_300K / fd_pkg::MUL_DEN);
      default: return 24'(QUARTER_CYC * fd_pkg::MUL_250K / fd_pkg::MUL_DEN);
    endcase
  endfunction
  function automatic logic [4:0] burstSize(input logic dis, input logic [3:0] thr);
    return dis ? 5'h01 : 5'({1'b0, thr} + 5'h01);
  endfunction

  // bus: one wait state, so each access completes on its second cycle
  assign waitrequest = (read | write) & ~ack_ff;
  assign wrOk = write & ack_ff & (byteenable == 4'hF);
  assign rdOk = read & ack_ff;
  assign readdata = readdata_ff;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      ack_ff <= 1'b0;
    else
      ack_ff <= (read | write) & ~ack_ff;
  end

  // read data captured in the wait cycle, stands at the completing edge
  always_ff @(posedge clk)
  begin
    if (!resetn)
      readdata_ff <= 32'h0000_0000;
    else if (read && !ack_ff)
      readdata_ff <= rdMux;
  end

  assign st3 = {1'b0, writeProtect, driveReady, trackZeroSense, 4'h0};

  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (address)
      fd_pkg::OFS_SPECIFY: rdMux = {16'h0000, nonDma_ff, loadCode_ff, stepCode_ff, unloadCode_ff};
      fd_pkg::OFS_CONFIG: rdMux = {16'h0000, precomp_ff, 1'b0, fifo_threshold_ff, pollDisable_ff,
                                   fifoDisable_ff, impliedSeek_ff};
      fd_pkg::OFS_RATE: rdMux = {29'h0000_0000, rate_ff};
      fd_pkg::OFS_STATUS: rdMux = {13'h0000, controllerIrq, hostTransferReady,
                                   state_ff != fd_pkg::S_IDLE, pcn_ff, st0_ff};
      fd_pkg::OFS_DRIVE: rdMux = {24'h00_0000, st3};
      fd_pkg::OFS_VERSION: rdMux = {24'h00_0000, VERSION_CODE};
      fd_pkg::OFS_SENSEINT: rdMux = {16'h0000, pcn_ff, st0_ff};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // timer setup and DMA mode, any time; timer codes take effect on the next timer load, the mode bit at once
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      unloadCode_ff <= 4'h0;
      stepCode_ff <= 4'h0;
      loadCode_ff <= 7'h00;
      nonDma_ff <= 1'b0;
    end
    else if (wrOk && address == fd_pkg::OFS_SPECIFY)
    begin
      unloadCode_ff <= writedata[fd_pkg::SPC_UNLOAD_LSB +: 4];
      stepCode_ff <= writedata[fd_pkg::SPC_STEP_LSB +: 4];
      loadCode_ff <= writedata[fd_pkg::SPC_LOAD_LSB +: 7];
      nonDma_ff <= writedata[fd_pkg::SPC_NONDMA_BIT];
    end
  end

  // feature configuration and data rate
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      impliedSeek_ff <= fd_pkg::RST_IMPLIED;
      fifoDisable_ff <= fd_pkg::RST_FIFODIS;
      pollDisable_ff <= fd_pkg::RST_POLLDIS;
      fifo_threshold_ff <= fd_pkg::RST_THR;
      precomp_ff <= fd_pkg::RST_PRECOMP;
      rate_ff <= fd_pkg::RST_RATE;
    end
    else if (wrOk && address == fd_pkg::OFS_CONFIG)
    begin
      impliedSeek_ff <= writedata[fd_pkg::CFG_IMPLIED_BIT];
      fifoDisable_ff <= writedata[fd_pkg::CFG_FIFODIS_BIT];
      pollDisable_ff <= writedata[fd_pkg::CFG_POLLDIS_BIT];
      fifo_threshold_ff <= writedata[fd_pkg::CFG_THR_LSB +: 4];
      precomp_ff <= writedata[fd_pkg::CFG_PRECOMP_LSB +: 8];
    end
    else if (wrOk && address == fd_pkg::OFS_RATE)
      rate_ff <= writedata[2:0];
  end

  // engine decisions; a new command is only taken when idle
  assign needSeek = impliedSeek_ff && (writedata[7:0] != pcn_ff);
  always_comb
  begin
    stepNow = 1'b0;
    finishNow = 1'b0;
    finishFault = 1'b0;
    loadNow = 1'b0;
    if (state_ff == fd_pkg::S_IDLE)
      loadNow = wrOk && (address == fd_pkg::OFS_XFER) && !needSeek;
    else if (state_ff == fd_pkg::S_STEP)
    begin
      unique case (op_ff)
        fd_pkg::OP_REL:
        begin
          finishNow = (remaining_ff == 8'h00) || (!dirIn_ff && trackZeroSense);
          finishFault = (remaining_ff != 8'h00) && !dirIn_ff && trackZeroSense;
        end
        fd_pkg::OP_RECAL:
        begin
          finishNow = trackZeroSense || (stepsDone_ff == fd_pkg::RECAL_LIMIT);
          finishFault = !trackZeroSense && (stepsDone_ff == fd_pkg::RECAL_LIMIT);
        end
        fd_pkg::OP_XFER:
          loadNow = (pcn_ff == target_ff);
      endcase
      stepNow = !finishNow && !loadNow;
    end
  end

  assign byteAck = (state_ff == fd_pkg::S_XFER) && !reqGap_ff
                   && (nonDma_ff ? (wrOk && address == fd_pkg::OFS_DATA) : dmaAck);
  assign xferDone = byteAck && (bytesLeft_ff == 9'h001);
  assign pollFire = !pollDone_ff && !pollDisable_ff && (state_ff == fd_pkg::S_IDLE)
                    && !(headLoaded_ff && unload_ff != 9'h000);

  // engine state, operation and step bookkeeping
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_ff <= fd_pkg::S_IDLE;
      op_ff <= fd_pkg::OP_REL;
      dirIn_ff <= 1'b0;
      remaining_ff <= 8'h00;
      stepsDone_ff <= 8'h00;
      target_ff <= 8'h00;
    end
    else
    begin
      unique case (state_ff)
        fd_pkg::S_IDLE:
        begin
          // commands written while busy are dropped, so only one seek runs
          if (wrOk && address == fd_pkg::OFS_RELSEEK)
          begin
            op_ff <= fd_pkg::OP_REL;
            dirIn_ff <= writedata[fd_pkg::CMD_DIR_BIT];
            remaining_ff <= writedata[7:0];
            stepsDone_ff <= 8'h00;
            state_ff <= fd_pkg::S_STEP;
          end
          else if (wrOk && address == fd_pkg::OFS_RECAL)
          begin
            op_ff <= fd_pkg::OP_RECAL;
            dirIn_ff <= 1'b0;
            stepsDone_ff <= 8'h00;
            state_ff <= fd_pkg::S_STEP;
          end
          else if (wrOk && address == fd_pkg::OFS_XFER)
          begin
            op_ff <= fd_pkg::OP_XFER;
            target_ff <= writedata[7:0];
            dirIn_ff <= writedata[7:0] > pcn_ff;
            stepsDone_ff <= 8'h00;
            state_ff <= needSeek ? fd_pkg::S_STEP : fd_pkg::S_LOAD;
          end
        end
        fd_pkg::S_STEP:
        begin
          if (finishNow)
            state_ff <= fd_pkg::S_IDLE;
          else if (loadNow)
            state_ff <= fd_pkg::S_LOAD;
          else
          begin
            remaining_ff <= remaining_ff - 8'h01;
            stepsDone_ff <= stepsDone_ff + 8'h01;
            state_ff <= fd_pkg::S_GAP;
          end
        end
        fd_pkg::S_GAP:
          if (timer_ff == 9'h000 && !stepPulse_ff)
            state_ff <= fd_pkg::S_STEP;
        fd_pkg::S_LOAD:
          if (timer_ff == 9'h000)
            state_ff <= fd_pkg::S_XFER;
        fd_pkg::S_XFER:
          if (xferDone)
            state_ff <= fd_pkg::S_IDLE;
      endcase
    end
  end

  // cylinder register: free wrap, never widened past 255
  always_ff @(posedge clk)
  begin
    if (!resetn)
      pcn_ff <= 8'h00;
    else if (finishNow && op_ff == fd_pkg::OP_RECAL && trackZeroSense)
      pcn_ff <= 8'h00;
    else if (stepNow)
      pcn_ff <= dirIn_ff ? pcn_ff + 8'h01 : pcn_ff - 8'h01;
  end

  // status 0, interrupt and the one-shot reset poll
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st0_ff <= 8'h00;
      irq_ff <= 1'b0;
      pollDone_ff <= 1'b0;
    end
    else
    begin
      if (finishNow)
      begin
        st0_ff <= 8'h00;
        st0_ff[7:6] <= finishFault ? fd_pkg::IC_ABNORMAL : fd_pkg::IC_NORMAL;
        st0_ff[fd_pkg::ST0_SEEKEND_BIT] <= 1'b1;
        st0_ff[fd_pkg::ST0_FAULT_BIT] <= finishFault;
      end
      else if (xferDone)
        st0_ff <= 8'h00;
      else if (pollFire)
        st0_ff <= {fd_pkg::IC_POLL, 6'h00};
      if (pollFire)
        pollDone_ff <= 1'b1;
      // a new event outranks a status read in the same cycle
      if (finishNow || xferDone || pollFire)
        irq_ff <= 1'b1;
      else if (rdOk && address == fd_pkg::OFS_SENSEINT)
        irq_ff <= 1'b0;
    end
  end

  // quarter-ms tick, restarted so each step gap and head load interval starts on a full period;
  // a step starts two counts in, paying for the gap-to-step hop and the pulse register
  assign tick = (prescale_ff == rateDiv(rate_ff) - 24'h00_0001);
  always_ff @(posedge clk)
  begin
    if (!resetn)
      prescale_ff <= 24'h00_0000;
    else if (stepNow)
      prescale_ff <= 24'h00_0002;
    else if (loadNow || tick)
      prescale_ff <= 24'h00_0000;
    else
      prescale_ff <= prescale_ff + 24'h00_0001;
  end

  // step gap and head load delay share one timer
  always_ff @(posedge clk)
  begin
    if (!resetn)
      timer_ff <= 9'h000;
    else if (stepNow)
      timer_ff <= stepQ(stepCode_ff);
    else if (loadNow)
      timer_ff <= headLoaded_ff ? 9'h000 : loadQ(loadCode_ff);
    else if (tick && timer_ff != 9'h000)
      timer_ff <= timer_ff - 9'h001;
  end

  // head load and unload delay, runs alongside idle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      headLoaded_ff <= 1'b0;
      unload_ff <= 9'h000;
    end
    else if (loadNow)
    begin
      headLoaded_ff <= 1'b1;
      unload_ff <= 9'h000;
    end
    else if (xferDone)
      unload_ff <= unloadQ(unloadCode_ff);
    else if (tick && unload_ff != 9'h000)
    begin
      unload_ff <= unload_ff - 9'h001;
      if (unload_ff == 9'h001)
        headLoaded_ff <= 1'b0;
    end
  end

  // step pulse width and direction output
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      stepWidth_ff <= 8'h00;
      stepPulse_ff <= 1'b0;
    end
    else if (stepNow)
    begin
      stepWidth_ff <= 8'(fd_pkg::STEP_WIDTH_CYC - 1);
      stepPulse_ff <= 1'b1;
    end
    else if (stepWidth_ff != 8'h00)
      stepWidth_ff <= stepWidth_ff - 8'h01;
    else
      stepPulse_ff <= 1'b0;
  end

  // byte count and request bursts; a gap cycle separates bursts
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      bytesLeft_ff <= 9'h000;
      burstLeft_ff <= 5'h00;
      reqGap_ff <= 1'b0;
    end
    else if (loadNow)
    begin
      bytesLeft_ff <= 9'(XFER_BYTES);
      burstLeft_ff <= burstSize(fifoDisable_ff, fifo_threshold_ff);
      reqGap_ff <= 1'b0;
    end
    else if (byteAck)
    begin
      bytesLeft_ff <= bytesLeft_ff - 9'h001;
      reqGap_ff <= (burstLeft_ff == 5'h01);
      burstLeft_ff <= (burstLeft_ff == 5'h01) ? burstSize(fifoDisable_ff, fifo_threshold_ff)
                                               : burstLeft_ff - 5'h01;
    end
    else
      reqGap_ff <= 1'b0;
  end

  assign stepPulse = stepPulse_ff;
  assign stepDirIn = dirIn_ff;
  assign headLoad = headLoaded_ff;
  // transfer requests routed by mode
  assign dmaRequest = (state_ff == fd_pkg::S_XFER) && !reqGap_ff && !nonDma_ff;
  assign hostTransferReady = (state_ff == fd_pkg::S_XFER) && !reqGap_ff && nonDma_ff;
  assign controllerIrq = irq_ff | hostTransferReady;

  sequence relOutAtZero;
    state_ff == fd_pkg::S_STEP && op_ff == fd_pkg::OP_REL && !dirIn_ff
      && remaining_ff != 8'h00 && trackZeroSense;
  endsequence
  sequence stepIssued;
    stepNow ##1 stepPulse_ff;
  endsequence

  a_drive_status: assert property (@(posedge clk) disable iff (!resetn)
    read && !ack_ff && address == fd_pkg::OFS_DRIVE |=> readdata[7:0] == $past(st3))
    else $error("drive status read wrong");
  a_version_code: assert property (@(posedge clk) disable iff (!resetn)
    read && !ack_ff && address == fd_pkg::OFS_VERSION |=> readdata == {24'h00_0000, VERSION_CODE})
    else $error("version code wrong");
  a_mode_route: assert property (@(posedge clk) disable iff (!resetn)
    (dmaRequest |-> !nonDma_ff) and (hostTransferReady |-> nonDma_ff && controllerIrq))
    else $error("transfer request on wrong path");
  a_step_fault: assert property (@(posedge clk) disable iff (!resetn)
    relOutAtZero |=> st0_ff[fd_pkg::ST0_FAULT_BIT] && state_ff == fd_pkg::S_IDLE && irq_ff)
    else $error("fault not raised at track zero");
  a_pcn_wrap: assert property (@(posedge clk) disable iff (!resetn)
    stepIssued |-> pcn_ff == ($past(dirIn_ff) ? $past(pcn_ff) + 8'h01
                                               : $past(pcn_ff) - 8'h01))
    else $error("cylinder register not stepped");
  a_recal_limit: assert property (@(posedge clk) disable iff (!resetn)
    op_ff == fd_pkg::OP_RECAL |-> stepsDone_ff <= fd_pkg::RECAL_LIMIT)
    else $error("recalibrate exceeded step limit");
  a_rel_count: assert property (@(posedge clk) disable iff (!resetn)
    state_ff == fd_pkg::S_STEP && op_ff == fd_pkg::OP_REL && remaining_ff == 8'h00
      |=> state_ff == fd_pkg::S_IDLE && !stepPulse_ff)
    else $error("relative seek overran its count");
  a_poll_once: assert property (@(posedge clk) disable iff (!resetn)
    $rose(pollDone_ff) |-> irq_ff && st0_ff[7:6] == fd_pkg::IC_POLL)
    else $error("poll interrupt missing");
  a_single_byte: assert property (@(posedge clk) disable iff (!resetn)
    byteAck && fifoDisable_ff && !loadNow |=> !dmaRequest && !hostTransferReady)
    else $error("burst with fifo disabled");
  a_step_gap: assert property (@(posedge clk) disable iff (!resetn)
    stepNow |=> timer_ff == $past(stepQ(stepCode_ff)))
    else $error("step gap not loaded");

endmodule

// file: fd_pkg.sv
/*
  Shared constants for the floppy drive positioning and configuration block:
  register byte offsets, field positions, reset values, timer encodings,
  timing figures and the enumerations of engine states and operations.
  Assumes a 200 MHz clock and a 32-bit Avalon-MM register port.
*/
package fd_pkg;

  // register byte offsets (word aligned)
  localparam logic [5:0] OFS_SPECIFY = 6'h00;
  localparam logic [5:0] OFS_CONFIG = 6'h04;
  localparam logic [5:0] OFS_RATE = 6'h08;
  localparam logic [5:0] OFS_RELSEEK = 6'h0C;
  localparam logic [5:0] OFS_RECAL = 6'h10;
  localparam logic [5:0] OFS_STATUS = 6'h14;
  localparam logic [5:0] OFS_DRIVE = 6'h18;
  localparam logic [5:0] OFS_VERSION = 6'h1C;
  localparam logic [5:0] OFS_SENSEINT = 6'h20;
  localparam logic [5:0] OFS_XFER = 6'h24;
  localparam logic [5:0] OFS_DATA = 6'h28;

  // field positions
  localparam int SPC_UNLOAD_LSB = 0;
  localparam int SPC_STEP_LSB = 4;
  localparam int SPC_LOAD_LSB = 8;
  localparam int SPC_NONDMA_BIT = 15;
  localparam int CFG_IMPLIED_BIT = 0;
  localparam int CFG_FIFODIS_BIT = 1;
  localparam int CFG_POLLDIS_BIT = 2;
  localparam int CFG_THR_LSB = 3;
  localparam int CFG_PRECOMP_LSB = 8;
  localparam int CMD_DIR_BIT = 8;
  localparam int ST0_FAULT_BIT = 4;
  localparam int ST0_SEEKEND_BIT = 5;
  localparam int ST3_TRKZERO_BIT = 4;
  localparam int ST3_READY_BIT = 5;
  localparam int ST3_WPROT_BIT = 6;

  // reset values
  localparam logic RST_IMPLIED = 1'b0;
  localparam logic RST_FIFODIS = 1'b1;
  localparam logic RST_POLLDIS = 1'b0;
  localparam logic [3:0] RST_THR = 4'h0;
  localparam logic [7:0] RST_PRECOMP = 8'h00;
  localparam logic [2:0] RST_RATE = 3'h0;

  // interrupt codes in the top two bits of status 0
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_POLL = 2'h3;

  // data rate codes and their timer stretch in thirds
  localparam logic [2:0] RATE_2M = 3'h0;
  localparam logic [2:0] RATE_1M = 3'h1;
  localparam logic [2:0] RATE_500K = 3'h2;
  localparam logic [2:0] RATE_300K = 3'h3;
  localparam logic [2:0] RATE_250K = 3'h4;
  localparam int MUL_2M = 3;
  localparam int MUL_1M = 6;
  localparam int MUL_500K = 12;
  localparam int MUL_300K = 20;
  localparam int MUL_250K = 24;
  localparam int MUL_DEN = 3;

  // timer encodings, in quarter milliseconds at the fastest rate
  localparam logic [8:0] UNLOAD_ZERO_Q = 9'h100;
  localparam logic [8:0] UNLOAD_STEP_Q = 9'h010;
  localparam logic [8:0] LOAD_ZERO_Q = 9'h100;
  localparam logic [8:0] LOAD_STEP_Q = 9'h002;
  localparam logic [8:0] STEP_TOP_Q = 9'h010;

  // timing
  localparam int CLK_NS = 5;
  localparam int QUARTER_MS_NS = 250000;
  localparam int STEP_WIDTH_NS = 1000;
  localparam int STEP_WIDTH_CYC = (STEP_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] RECAL_LIMIT = 8'h50;
  localparam int XFER_BYTES_DEF = 16;

  typedef enum logic [2:0] {S_IDLE, S_STEP, S_GAP, S_LOAD, S_XFER} eng_state_t;
  typedef enum logic [1:0] {OP_REL, OP_RECAL, OP_XFER} eng_op_t;

endpackage

// file: fd_drive_model.sv
/* drive stand-in: head position, track zero sense, dma acks
   assumes one drive and step pulses several cycles wide */
`timescale 1ns/1ps
module fd_drive_model (
  // clock
  input wire logic clk,
  // head
  input wire logic stepPulse,
  input wire logic stepDirIn,
  output logic trackZeroSense,
  // dma
  input wire logic dmaRequest,
  output logic dmaAck
);
  int pos = 0;
  int gap = 0;
  int last = 0;
  int acks = 0;
  logic stepQ = 1'b0;
  // head stops at track zero; last keeps rise-to-rise spacing
  always @(posedge clk)
  begin
    stepQ <= stepPulse;
    gap <= gap + 1;
    if (stepPulse && !stepQ)
    begin
      pos <= stepDirIn ? pos + 1 : (pos > 0 ? pos - 1 : 0);
      last <= gap;
      gap <= 1;
    end
  end
  assign trackZeroSense = (pos == 0);
  // slow acks, only every third cycle, so requests must wait
  initial dmaAck = 1'b0;
  always @(posedge clk)
  begin
    dmaAck <= dmaRequest && !dmaAck && (gap % 3 == 0);
    acks <= acks + int'(dmaAck);
  end
endmodule

// file: testbench.sv
/* self-checking bench for the positioning and configuration block
   assumes the drive stand-in of fd_drive_model.sv */
`timescale 1ns/1ps
module testbench;
  localparam int QC = 16;
  // worst case near 74k cycles, most of it 200-cycle step pulses in the wrap test
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest, stepPulse, stepDirIn, headLoad, trackZeroSense;
  logic dmaRequest, dmaAck, hostTransferReady, controllerIrq;
  logic writeProtect = 1'b0;
  logic driveReady = 1'b0;
  logic [31:0] rd;
  int err_count = 0;
  int comparisons = 0;
  int seed = 35;
  int cycles = 0;
  int ld = 0;
  int n;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  floppy_ctrl_config_and_relseek #(.QUARTER_CYC(QC), .XFER_BYTES(4))
    floppy_ctrl_config_and_relseek_inst (.clk(clk), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .stepPulse(stepPulse),
    .stepDirIn(stepDirIn), .headLoad(headLoad), .trackZeroSense(trackZeroSense),
    .writeProtect(writeProtect), .driveReady(driveReady), .dmaRequest(dmaRequest),
    .dmaAck(dmaAck), .hostTransferReady(hostTransferReady), .controllerIrq(controllerIrq));
  fd_drive_model fd_drive_model_inst (.clk(clk), .stepPulse(stepPulse),
    .stepDirIn(stepDirIn), .trackZeroSense(trackZeroSense), .dmaRequest(dmaRequest),
    .dmaAck(dmaAck));
  // hang guard and head-loaded cycle count
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    ld <= headLoad ? ld + 1 : 0;
    if (cycles == LIMIT)
    begin
      err_count++;
      close_out();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    cmp(rd, e);
  endtask
  // poll busy; a stuck engine is caught by the hang guard
  task automatic idle();
    do
      bus(1'b0, fd_pkg::OFS_STATUS, 32'h0000_0000);
    while (rd[16] !== 1'b0);
  endtask
  function automatic int spc(int code, int mul);
    return (16 - code) * QC * mul / fd_pkg::MUL_DEN;
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    writeProtect <= 1'($random(seed));
    driveReady <= 1'($random(seed));
    rdc(fd_pkg::OFS_STATUS, 32'h0004_00C0);
    rdc(fd_pkg::OFS_SENSEINT, 32'h0000_00C0);
    #1;
    cmp({31'h0, controllerIrq}, 32'h0);
    rdc(fd_pkg::OFS_CONFIG, 32'h0000_0002);
    rdc(fd_pkg::OFS_VERSION, 32'h0000_005A);
    rdc(fd_pkg::OFS_DRIVE, {25'h0, writeProtect, driveReady, 5'h10});
    rdc(6'h3C, 32'h0000_0000);
    $display("query test done");
    bus(1'b1, fd_pkg::OFS_SPECIFY, 32'h0000_81F1);
    bus(1'b1, fd_pkg::OFS_RELSEEK, 32'h0000_0003);
    idle();
    rdc(fd_pkg::OFS_SENSEINT, 32'h0000_0070);
    $display("outward fault test done");
    // step spacing at two rates and codes, three steps in each
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, fd_pkg::OFS_RATE, i ? 32'h4 : 32'h1);
      bus(1'b1, fd_pkg::OFS_SPECIFY, i ? 32'h0000_8181 : 32'h0000_8101);
      bus(1'b1, fd_pkg::OFS_RELSEEK, 32'h0000_0103);
      idle();
      cmp(fd_drive_model_inst.last, spc(i * 8, i ? fd_pkg::MUL_250K : fd_pkg::MUL_1M));
      cmp({31'h0, controllerIrq}, 32'h1);
      rdc(fd_pkg::OFS_SENSEINT, i ? 32'h0000_0620 : 32'h0000_0320);
    end
    $display("step spacing test done");
    bus(1'b1, fd_pkg::OFS_RATE, 32'h0000_0000);
    bus(1'b1, fd_pkg::OFS_SPECIFY, 32'h0000_81F1);
    bus(1'b1, fd_pkg::OFS_XFER, 32'h0000_0006);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      while (hostTransferReady !== 1'b1)
        @(posedge clk);
      if (i == 0)
        cmp({31'h0, ld >= 2 * QC && ld <= 2 * QC + 2}, 32'h1);
      cmp({31'h0, dmaRequest}, 32'h0);
      bus(1'b1, fd_pkg::OFS_DATA, 32'h0000_00A5);
    end
    idle();
    bus(1'b1, fd_pkg::OFS_CONFIG, 32'h0000_0003);
    bus(1'b1, fd_pkg::OFS_SPECIFY, 32'h0000_01F1);
    bus(1'b1, fd_pkg::OFS_XFER, 32'h0000_0008);
    idle();
    cmp(fd_drive_model_inst.pos, 8);
    cmp(fd_drive_model_inst.acks, 4);
    $display("transfer test done");
    n = 236 + ($random(seed) & 15);
    bus(1'b1, fd_pkg::OFS_RELSEEK, 32'h100 | 32'(n));
    idle();
    bus(1'b1, fd_pkg::OFS_RELSEEK, 32'h0000_010C);
    idle();
    rdc(fd_pkg::OFS_SENSEINT, {16'h0, 8'(n + 20), 8'h20});
    cmp(fd_drive_model_inst.pos, n + 20);
    bus(1'b1, fd_pkg::OFS_RECAL, 32'h0000_0001);
    idle();
    cmp(fd_drive_model_inst.pos, n - 60);
    bus(1'b0, fd_pkg::OFS_SENSEINT, 32'h0000_0000);
    cmp({24'h0, rd[7:0]}, 32'h0000_0070);
    $display("wrap and recalibrate test done");
    close_out();
  end
endmodule
